// ### pscf_pkg.sv
// package: offsets, field positions, reset values and codes of the status/control/flag group
package pscf_pkg;
    localparam logic [7:0] status_offset = 8'h05;
    localparam logic [7:0] control_offset = 8'h06;
    localparam logic [7:0] flag_offset = 8'h07;
    localparam int seal_pos = 7;
    localparam int nvm_pos = 6;
    localparam int adapter_pos = 5;
    localparam int button_pos = 4;
    localparam int seq_lsb = 2;
    localparam int coin_lsb = 0;
    localparam int measure_pos = 0;
    localparam int pf_enable_pos = 1;
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [7:0] flag_reset = 8'h00;
    localparam logic [1:0] coin_reset = 2'h0;
    localparam logic [1:0] seq_code_transition = 2'h0;
    localparam logic [1:0] seq_code_wait_power = 2'h1;
    localparam logic [1:0] seq_code_active = 2'h2;
    localparam logic [1:0] seq_code_suspend = 2'h3;
    localparam int sync_stages = 3;
    typedef enum logic [1:0] {
        pscf_seq_transition,
        pscf_seq_wait_power,
        pscf_seq_active,
        pscf_seq_suspend
    } pscf_seq_t;
endpackage : pscf_pkg

// ### pscf_pin_sync.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pscf_pin_sync #(
    parameter int width = 2,
    parameter logic [1:0] init = 2'h3
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [width-1:0] pin,
    output logic [width-1:0] level
);
    typedef struct packed {
        logic [width-1:0] s1;
        logic [width-1:0] s2;
        logic [width-1:0] s3;
        logic [width-1:0] lvl;
    } pscf_sync_t;
    pscf_sync_t q;
    pscf_sync_t d;
    // refuse widths the two-pin packing cannot serve
    if (width < 1 || width > 2) begin : g_width_check
        $error("pscf_pin_sync: width must be 1 or 2");
    end
    always_comb begin
        d = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < width; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.lvl[i] = q.s3[i];
            end
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= {4{init[width-1:0]}};
        end else begin
            q <= d;
        end
    end
    assign level = q.lvl;
endmodule : pscf_pin_sync

// ### pscf_regs.sv
// status, control and suspend-retention flag registers of the power controller
`timescale 1ns/1ps
// How it works
// - status bit 7: seal broken, reset 0
// - status bit 6: nvm defaults changed, reset 0
// - status bit 5: adapter pin low reads 1
// - status bit 4: button pin low reads 1
// - status bits 3:2 encode sequencer state
// - status bits 1:0 encode coin-cell level
// - control bit 0 starts measurement, self-clears
// - control bit 1: power fail shuts down
// - control bits 7:2 read zero
// - flags captured on power-up from suspend
// - flag bit order outputs, regulator, converters
module pscf_regs #(
    parameter int flag_width = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic factory_seal_broken,
    input wire logic nvm_defaults_modified,
    input wire logic adapter_detect_pin,
    input wire logic pushbutton_pin,
    input wire pscf_pkg::pscf_seq_t seq_state,
    output logic coin_cell_measure_start,
    input wire logic coin_measure_done,
    input wire logic [1:0] coin_measure_result,
    input wire logic power_fail_output_n,
    output logic power_fail_shutdown,
    input wire logic power_up_strobe,
    input wire logic power_up_from_suspend,
    input wire logic [flag_width-1:0] suspend_enables
);
    typedef struct packed {
        logic measure;
        logic pf_enable;
        logic [1:0] coin;
        logic [flag_width-1:0] flags;
        logic [7:0] rdata;
    } pscf_state_t;
    pscf_state_t q;
    pscf_state_t d;
    logic [1:0] pin_level;
    logic [7:0] status_word;
    logic [7:0] control_word;
    logic [1:0] seq_code;
    // the flag register is one byte wide
    if (flag_width != 8) begin : g_width_check
        $error("pscf_regs: flag_width must be 8");
    end
    pscf_pin_sync #(
        .width(2),
        .init(2'h3)
    ) u_pin_sync (
        .clk(clk),
        .nrst(nrst),
        .pin({adapter_detect_pin, pushbutton_pin}),
        .level(pin_level)
    );
    always_comb begin
        unique case (seq_state)
            pscf_pkg::pscf_seq_transition: seq_code = pscf_pkg::seq_code_transition;
            pscf_pkg::pscf_seq_wait_power: seq_code = pscf_pkg::seq_code_wait_power;
            pscf_pkg::pscf_seq_active: seq_code = pscf_pkg::seq_code_active;
            pscf_pkg::pscf_seq_suspend: seq_code = pscf_pkg::seq_code_suspend;
        endcase
    end
    always_comb begin
        status_word = 8'h00;
        status_word[pscf_pkg::seal_pos] = factory_seal_broken;
        status_word[pscf_pkg::nvm_pos] = nvm_defaults_modified;
        status_word[pscf_pkg::adapter_pos] = ~pin_level[1];
        status_word[pscf_pkg::button_pos] = ~pin_level[0];
        status_word[pscf_pkg::seq_lsb +: 2] = seq_code;
        status_word[pscf_pkg::coin_lsb +: 2] = q.coin;
        control_word = 8'h00;
        control_word[pscf_pkg::measure_pos] = q.measure;
        control_word[pscf_pkg::pf_enable_pos] = q.pf_enable;
    end
    always_comb begin
        d = q;
        d.measure = 1'b0;
        if (coin_measure_done) begin
            d.coin = coin_measure_result;
        end
        if (reg_wr && reg_addr == pscf_pkg::control_offset) begin
            d.measure = reg_wdata[pscf_pkg::measure_pos];
            d.pf_enable = reg_wdata[pscf_pkg::pf_enable_pos];
        end
        if (power_up_strobe) begin
            d.flags = power_up_from_suspend ? suspend_enables : pscf_pkg::flag_reset;
        end
        unique case (reg_addr)
            pscf_pkg::status_offset: d.rdata = status_word;
            pscf_pkg::control_offset: d.rdata = control_word;
            pscf_pkg::flag_offset: d.rdata = q.flags;
            default: d.rdata = 8'h00;
        endcase
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q.measure <= pscf_pkg::control_reset[pscf_pkg::measure_pos];
            q.pf_enable <= pscf_pkg::control_reset[pscf_pkg::pf_enable_pos];
            q.coin <= pscf_pkg::coin_reset;
            q.flags <= pscf_pkg::flag_reset;
            q.rdata <= 8'h00;
        end else begin
            q <= d;
        end
    end
    assign reg_rdata = q.rdata;
    assign coin_cell_measure_start = q.measure;
    assign power_fail_shutdown = q.pf_enable & ~power_fail_output_n;
endmodule : pscf_regs

// ### pscf_regs_chk.sv
// checker: port timing of the register group
`timescale 1ns/1ps
module pscf_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic reg_wr,
    input wire logic coin_cell_measure_start,
    input wire logic power_fail_output_n,
    input wire logic power_fail_shutdown,
    input wire logic power_up_strobe,
    input wire logic power_up_from_suspend,
    input wire logic factory_seal_broken,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] suspend_enables
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic cw = reg_wr && reg_addr == 8'h06;
    wire logic fr = reg_addr == 8'h07;
    property p_st; coin_cell_measure_start == $past(cw && reg_wdata[0]); endproperty
    a_st: assert property (p_st) else $error("start");
    property p_on; cw && reg_wdata[1] ##1 !power_fail_output_n |-> power_fail_shutdown; endproperty
    a_on: assert property (p_on) else $error("no stop");
    property p_of; cw && !reg_wdata[1] |=> !power_fail_shutdown; endproperty
    a_of: assert property (p_of) else $error("stop");
    property p_pf; power_fail_output_n |-> !power_fail_shutdown; endproperty
    a_pf: assert property (p_pf) else $error("stop");
    property p_rs; $past(reg_addr) == 8'h06 |-> reg_rdata[7:2] == 6'h00; endproperty
    a_rs: assert property (p_rs) else $error("reserved");
    property p_se; $past(nrst && reg_addr == 8'h05) |-> reg_rdata[7] == $past(factory_seal_broken);
    endproperty
    a_se: assert property (p_se) else $error("seal");
    property p_cp; $past(power_up_strobe && fr, 2) && $past(fr) |->
        reg_rdata == $past(power_up_from_suspend ? suspend_enables : 8'h00, 2); endproperty
    a_cp: assert property (p_cp) else $error("capture");
    property p_hd; $past(fr, 2) && $past(fr) && !$past(power_up_strobe, 2) |-> $stable(reg_rdata);
    endproperty
    a_hd: assert property (p_hd) else $error("flags moved");
endmodule : pscf_chk
bind pscf_regs pscf_chk pscf_chk_i (.*);

// ### pscf_host.sv
// host model: register writes and reads at the falling edge
`timescale 1ns/1ps
module pscf_host (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00,
    output logic reg_wr = 1'h0
);
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'h1};
        @(negedge clk);
        reg_wr = 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd
endmodule : pscf_host

// ### tb_top.sv
// testbench: status, control and flag registers
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'h0, nrst = 1'h0, seal = 1'h0, nvm = 1'h0, ac_n = 1'h1, pb_n = 1'h1;
    logic done = 1'h0, pf_n = 1'h1, pu = 1'h0, sus = 1'h0, wr, st, shut;
    logic [1:0] coin = 2'h0;
    logic [7:0] en = 8'h00, addr, wd, rdata, v;
    pscf_pkg::pscf_seq_t seq = pscf_pkg::pscf_seq_transition;
    int errors = 0, samples_checked = 0, cyc = 0;
    always #20 clk = ~clk;
    pscf_host pscf_host_i (.clk, .reg_rdata(rdata), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr));
    pscf_regs pscf_regs_i (.clk, .nrst, .reg_addr(addr), .reg_wr(wr), .reg_wdata(wd),
        .reg_rdata(rdata), .factory_seal_broken(seal), .nvm_defaults_modified(nvm),
        .adapter_detect_pin(ac_n), .pushbutton_pin(pb_n), .seq_state(seq),
        .coin_cell_measure_start(st), .coin_measure_done(done), .coin_measure_result(coin),
        .power_fail_output_n(pf_n), .power_fail_shutdown(shut), .power_up_strobe(pu),
        .power_up_from_suspend(sus), .suspend_enables(en));
    task automatic chk(string n, logic [7:0] s, e);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic t_ctl;
        pscf_host_i.rd(8'h06, v);
        chk("ctl", v, 8'h00);
        pf_n = 1'h0;
        pscf_host_i.wr(8'h06, 8'hff);
        chk("shut", 8'(shut), 8'h01);
        chk("start", 8'(st), 8'h01);
        pscf_host_i.wr(8'h05, 8'h00);
        chk("start", 8'(st), 8'h00);
        pscf_host_i.rd(8'h06, v);
        chk("ctl", v, 8'h02);
        pscf_host_i.rd(8'h20, v);
        chk("unmapped", v, 8'h00);
        pscf_host_i.wr(8'h06, 8'h00);
        chk("shut", 8'(shut), 8'h00);
        pf_n = 1'h1;
        $display("control done");
    endtask : t_ctl
    task automatic t_status;
        for (int i = 0; i < 4; i++) begin
            pscf_host_i.wr(8'h06, 8'h01);
            {seal, nvm, ac_n, pb_n, done, coin} = {i[1], i[0], i[1], i[0], 1'h1, 2'(3 - i)};
            seq = pscf_pkg::pscf_seq_t'(i);
            repeat (5) @(negedge clk) done = 1'h0;
            pscf_host_i.rd(8'h05, v);
            chk("status", v, {i[1:0], ~i[1:0], i[1:0], 2'(3 - i)});
        end
        $display("status done");
    endtask : t_status
    task automatic t_flags;
        pscf_host_i.rd(8'h07, v);
        chk("flags", v, 8'h00);
        {pu, sus, en} = {2'h3, 8'ha5};
        @(negedge clk) {pu, en} = {1'h0, 8'h5a};
        pscf_host_i.rd(8'h07, v);
        chk("flags", v, 8'ha5);
        {pu, sus} = 2'h2;
        @(negedge clk) pu = 1'h0;
        pscf_host_i.rd(8'h07, v);
        chk("flags", v, 8'h00);
        $display("flags done");
    endtask : t_flags
    always @(posedge clk) if (++cyc > 2000) begin
        errors++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk) nrst = 1'h1;
        t_flags();
        t_ctl();
        t_status();
        give_verdict();
    end
endmodule : tb_top
